// ===== design/dpc_pkg.sv
// constants and carrier types of the dual pulse counter
package dpc_pkg;
  // structure
  localparam int DPC_CHANNELS       = 2;
  localparam int DPC_PINS           = 10;
  localparam int DPC_GPI_POINTS     = 8;
  localparam int DPC_GPI_USED       = 6;
  localparam int DPC_AW             = 8;
  localparam int DPC_DW             = 32;
  localparam int DPC_CW             = 32;
  localparam int DPC_DBNC_W         = 8;
  localparam int DPC_DBNC_CNT_W     = 18;
  // pin map
  localparam int DPC_PIN_PULSE_BASE = 0;
  localparam int DPC_PIN_HEN_BASE   = 2;
  localparam int DPC_PIN_HCLR_BASE  = 4;
  localparam int DPC_PIN_GPI_BASE   = 4;
  // register offsets
  localparam logic [7:0] DPC_OFS_CTRL   = 8'h00;
  localparam logic [7:0] DPC_OFS_DBNC1  = 8'h04;
  localparam logic [7:0] DPC_OFS_DBNC2  = 8'h08;
  localparam logic [7:0] DPC_OFS_COUNT1 = 8'h0c;
  localparam logic [7:0] DPC_OFS_COUNT2 = 8'h10;
  localparam logic [7:0] DPC_OFS_GPI    = 8'h14;
  localparam logic [7:0] DPC_OFS_STATUS = 8'h18;
  // control field positions, one bit per channel from each base
  localparam int DPC_CTRL_SW_EN_POS  = 0;
  localparam int DPC_CTRL_SW_CLR_POS = 4;
  localparam int DPC_CTRL_HEN_POS    = 8;
  localparam int DPC_CTRL_HCLR_POS   = 12;
  // status field positions
  localparam int DPC_STS_EN_POS      = 0;
  localparam int DPC_STS_HELD_POS    = 4;
  localparam int DPC_STS_LEVEL_POS   = 8;
  // debounce codes and reset value
  localparam logic [7:0] DPC_DBNC_15K  = 8'h02;
  localparam logic [7:0] DPC_DBNC_10K  = 8'h04;
  localparam logic [7:0] DPC_DBNC_5K   = 8'h08;
  localparam logic [7:0] DPC_DBNC_2K5  = 8'h10;
  localparam logic [7:0] DPC_DBNC_1K   = 8'h28;
  localparam logic [7:0] DPC_DBNC_RST  = DPC_DBNC_15K;
  localparam logic [DPC_CW-1:0] DPC_COUNT_RST = 32'h0000_0000;
  // timing: one debounce unit, rounded up to whole cycles
  localparam int DPC_CLK_NS         = 25;
  localparam int DPC_DBNC_UNIT_NS   = 16000;
  localparam int DPC_DBNC_UNIT_CYC  = (DPC_DBNC_UNIT_NS + DPC_CLK_NS - 1) / DPC_CLK_NS;

  // per channel software configuration
  typedef struct packed {
    logic                  sw_en;
    logic                  sw_clr;
    logic                  hen_permit;
    logic                  hclr_permit;
    logic [DPC_DBNC_W-1:0] dbnc;
  } dpc_chan_cfg_type;

  // per channel synchronised field pins
  typedef struct packed {
    logic pulse;
    logic hw_en;
    logic hw_clr;
  } dpc_chan_pins_type;
endpackage : dpc_pkg

// ===== design/dpc_channel.sv
// one pulse counting channel with debounce filter
`timescale 1ns/100ps
`default_nettype none
module dpc_channel #(
  parameter int UNIT_CYC = dpc_pkg::DPC_DBNC_UNIT_CYC
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_b,
  input  wire dpc_pkg::dpc_chan_pins_type  i_pins,
  input  wire dpc_pkg::dpc_chan_cfg_type   i_cfg,
  output logic [dpc_pkg::DPC_CW-1:0]       o_count,
  output logic                             o_enabled,
  output logic                             o_held,
  output logic                             o_level
);
  import dpc_pkg::*;

  logic                      filt_r, filt_nxt;
  logic [DPC_DBNC_CNT_W-1:0] stab_r, stab_nxt;
  logic [DPC_CW-1:0]         count_r, count_nxt;
  logic [DPC_DBNC_CNT_W-1:0] limit;
  logic [DPC_DBNC_CNT_W-1:0] code_eff;
  logic                      accept;
  logic                      rise;

  // enable and hold terms, external ones only when permitted
  assign o_enabled = i_cfg.sw_en | (i_cfg.hen_permit & i_pins.hw_en);
  assign o_held    = i_cfg.sw_clr | (i_cfg.hclr_permit & i_pins.hw_clr);

  // debounce: level must differ for code units (one unit for code zero) before it is taken
  always_comb begin
    code_eff = (i_cfg.dbnc == '0) ? DPC_DBNC_CNT_W'(1) : DPC_DBNC_CNT_W'(i_cfg.dbnc);
    limit    = code_eff * DPC_DBNC_CNT_W'(UNIT_CYC);
    accept   = (i_pins.pulse != filt_r) && (stab_r >= limit - 1'b1);
    rise     = accept & i_pins.pulse;
    filt_nxt = filt_r;
    stab_nxt = '0;
    if (accept) begin
      filt_nxt = i_pins.pulse;
    end else if (i_pins.pulse != filt_r) begin
      stab_nxt = stab_r + 1'b1;
    end
  end

  // count: hold clears, enabled rising edge adds one
  always_comb begin
    count_nxt = count_r;
    if (o_held) begin
      count_nxt = DPC_COUNT_RST;
    end else if (o_enabled && rise) begin
      count_nxt = count_r + 1'b1;
    end
  end

  // registers
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      filt_r  <= 1'b0;
      stab_r  <= '0;
      count_r <= DPC_COUNT_RST;
    end else begin
      filt_r  <= filt_nxt;
      stab_r  <= stab_nxt;
      count_r <= count_nxt;
    end
  end

  assign o_count = count_r;
  assign o_level = filt_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_held_zero;
    o_held |=> count_r == '0;
  endproperty
  a_held_zero: assert property (p_held_zero) else $error("count not cleared while held");

  property p_step;
    (count_r != $past(count_r)) |-> (count_r == $past(count_r) + 1'b1) || (count_r == '0);
  endproperty
  a_step: assert property (p_step) else $error("count moved by other than one");

  property p_disabled;
    !o_enabled && !o_held |=> count_r == $past(count_r);
  endproperty
  a_disabled: assert property (p_disabled) else $error("count moved while disabled");

  property p_hen_ignored;
    !i_cfg.hen_permit && !i_cfg.sw_en && !o_held |=> count_r == $past(count_r);
  endproperty
  a_hen_ignored: assert property (p_hen_ignored) else $error("forbidden hw enable counted");

  property p_hclr_ignored;
    !i_cfg.hclr_permit && !i_cfg.sw_clr && o_enabled && rise |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_hclr_ignored: assert property (p_hclr_ignored) else $error("forbidden hw clear acted");

  property p_sw_en;
    i_cfg.sw_en && rise && !o_held |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_sw_en: assert property (p_sw_en) else $error("sw enabled pulse not counted");

  property p_dbnc;
    (filt_r != $past(filt_r)) |-> $past(stab_r) >= $past(limit) - 1'b1;
  endproperty
  a_dbnc: assert property (p_dbnc) else $error("filter changed too early");
endmodule : dpc_channel
`default_nettype wire

// ===== design/dpc_top.sv
// dual pulse counter top: pin sync, registers, two channels
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - two independent counting channels, each up to 15 kHz, no cross effect.
// - ten field inputs; six of them also readable as general inputs.
// - each channel has software clear, software enable, optional hardware clear and enable.
// - count advances only while enabled by software or permitted hardware enable.
// - each channel count is a read-only 32-bit value, channels 1 and 2.
// - software enable on counts; off disables only without active hardware enable.
// - software clear holds count at zero; otherwise counts unless hardware clear active.
// - per-channel permit bit gates the external enable; forbidden means ignored.
// - per-channel permit bit gates the external clear; forbidden means ignored.
// - debounce code sets max rate: 2,4,8,16,40 give 15,10,5,2.5,1 kHz; default 15.
// - general inputs read as eight read-only points 0 to 7, one byte.
module dpc_top #(
  parameter int DBNC_UNIT_CYC = dpc_pkg::DPC_DBNC_UNIT_CYC
) (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_rst_b,
  input  wire logic [dpc_pkg::DPC_PINS-1:0] i_field_in,
  input  wire logic [dpc_pkg::DPC_AW-1:0]  i_addr,
  input  wire logic [dpc_pkg::DPC_DW-1:0]  i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic [dpc_pkg::DPC_DW-1:0]       o_rdata
);
  import dpc_pkg::*;

  logic [DPC_PINS-1:0]       meta_r;
  logic [DPC_PINS-1:0]       sync_r;
  dpc_chan_cfg_type          cfg_r   [DPC_CHANNELS];
  dpc_chan_cfg_type          cfg_nxt [DPC_CHANNELS];
  dpc_chan_pins_type         pins    [DPC_CHANNELS];
  logic [DPC_CW-1:0]         count   [DPC_CHANNELS];
  logic [DPC_CHANNELS-1:0]   enabled;
  logic [DPC_CHANNELS-1:0]   held;
  logic [DPC_CHANNELS-1:0]   level;
  logic [DPC_GPI_POINTS-1:0] gpi;
  logic [DPC_DW-1:0]         rdata_r, rdata_nxt;

  // two-stage synchroniser on every field pin
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= i_field_in;
      sync_r <= meta_r;
    end
  end

  // general input points: six shared pins, upper points read zero
  always_comb begin
    gpi = '0;
    for (int p = 0; p < DPC_GPI_USED; p++) begin
      gpi[p] = sync_r[DPC_PIN_GPI_BASE + p];
    end
  end

  // configuration write decode
  always_comb begin
    for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
      cfg_nxt[ch] = cfg_r[ch];
    end
    if (i_wr) begin
      if (i_addr == DPC_OFS_CTRL) begin
        for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
          cfg_nxt[ch].sw_en       = i_wdata[DPC_CTRL_SW_EN_POS + ch];
          cfg_nxt[ch].sw_clr      = i_wdata[DPC_CTRL_SW_CLR_POS + ch];
          cfg_nxt[ch].hen_permit  = i_wdata[DPC_CTRL_HEN_POS + ch];
          cfg_nxt[ch].hclr_permit = i_wdata[DPC_CTRL_HCLR_POS + ch];
        end
      end else if (i_addr == DPC_OFS_DBNC1) begin
        cfg_nxt[0].dbnc = i_wdata[DPC_DBNC_W-1:0];
      end else if (i_addr == DPC_OFS_DBNC2) begin
        cfg_nxt[1].dbnc = i_wdata[DPC_DBNC_W-1:0];
      end
    end
  end

  // configuration registers, debounce defaults to the 15 kHz code
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
        cfg_r[ch].sw_en       <= 1'b0;
        cfg_r[ch].sw_clr      <= 1'b0;
        cfg_r[ch].hen_permit  <= 1'b0;
        cfg_r[ch].hclr_permit <= 1'b0;
        cfg_r[ch].dbnc        <= DPC_DBNC_RST;
      end
    end else begin
      for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
        cfg_r[ch] <= cfg_nxt[ch];
      end
    end
  end

  // one self-contained channel per counter
  for (genvar ch = 0; ch < DPC_CHANNELS; ch++) begin : g_chan
    // one driver per element: pulse, hw enable, hw clear in struct order
    assign pins[ch] = {sync_r[DPC_PIN_PULSE_BASE + ch], sync_r[DPC_PIN_HEN_BASE + ch],
                       sync_r[DPC_PIN_HCLR_BASE + ch]};

    dpc_channel #(
      .UNIT_CYC (DBNC_UNIT_CYC)
    ) u_chan (
      .i_sys_clk (i_sys_clk),
      .i_rst_b   (i_rst_b),
      .i_pins    (pins[ch]),
      .i_cfg     (cfg_r[ch]),
      .o_count   (count[ch]),
      .o_enabled (enabled[ch]),
      .o_held    (held[ch]),
      .o_level   (level[ch])
    );
  end

  // read decode, data valid only in the cycle after the strobe
  always_comb begin
    rdata_nxt = '0;
    if (i_rd) begin
      if (i_addr == DPC_OFS_CTRL) begin
        for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
          rdata_nxt[DPC_CTRL_SW_EN_POS + ch]  = cfg_r[ch].sw_en;
          rdata_nxt[DPC_CTRL_SW_CLR_POS + ch] = cfg_r[ch].sw_clr;
          rdata_nxt[DPC_CTRL_HEN_POS + ch]    = cfg_r[ch].hen_permit;
          rdata_nxt[DPC_CTRL_HCLR_POS + ch]   = cfg_r[ch].hclr_permit;
        end
      end else if (i_addr == DPC_OFS_DBNC1) begin
        rdata_nxt[DPC_DBNC_W-1:0] = cfg_r[0].dbnc;
      end else if (i_addr == DPC_OFS_DBNC2) begin
        rdata_nxt[DPC_DBNC_W-1:0] = cfg_r[1].dbnc;
      end else if (i_addr == DPC_OFS_COUNT1) begin
        rdata_nxt = count[0];
      end else if (i_addr == DPC_OFS_COUNT2) begin
        rdata_nxt = count[1];
      end else if (i_addr == DPC_OFS_GPI) begin
        rdata_nxt[DPC_GPI_POINTS-1:0] = gpi;
      end else if (i_addr == DPC_OFS_STATUS) begin
        for (int ch = 0; ch < DPC_CHANNELS; ch++) begin
          rdata_nxt[DPC_STS_EN_POS + ch]    = enabled[ch];
          rdata_nxt[DPC_STS_HELD_POS + ch]  = held[ch];
          rdata_nxt[DPC_STS_LEVEL_POS + ch] = level[ch];
        end
      end
    end
  end

  // read data register
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);

  property p_rd_count;
    i_rd && (i_addr == DPC_OFS_COUNT2) |=> o_rdata == $past(count[1]);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("count read mismatch");

  property p_rd_idle;
    !i_rd |=> o_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_gpi;
    i_rd && (i_addr == DPC_OFS_GPI) |=> o_rdata == {24'h00_0000, $past(gpi)};
  endproperty
  a_gpi: assert property (p_gpi) else $error("general input read mismatch");

  property p_gpi_pin;
    gpi[DPC_GPI_USED-1] == sync_r[DPC_PIN_GPI_BASE + DPC_GPI_USED - 1] && gpi[DPC_GPI_POINTS-1] == 1'b0;
  endproperty
  a_gpi_pin: assert property (p_gpi_pin) else $error("general input mapping wrong");

  property p_ctrl_wr;
    i_wr && (i_addr == DPC_OFS_CTRL) |=> cfg_r[1].sw_en == $past(i_wdata[DPC_CTRL_SW_EN_POS + 1]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("enable write not taken");

  property p_indep;
    held[0] && !held[1] |=> count[1] == $past(count[1]) || count[1] == $past(count[1]) + 1'b1;
  endproperty
  a_indep: assert property (p_indep) else $error("clear leaked across channels");

  c_cnt0: cover property (count[0] == $past(count[0]) + 1'b1);
  c_cnt1: cover property (count[1] == $past(count[1]) + 1'b1);
  c_hwclr: cover property (cfg_r[0].hclr_permit && pins[0].hw_clr && count[0] == '0);
  c_rd: cover property (i_rd && i_addr == DPC_OFS_COUNT1 && count[0] != '0);
endmodule : dpc_top
`default_nettype wire

// ===== test/dpc_field_model.sv
// field side model: pulse sources, hw enable/clear levels, general inputs
`timescale 1ns/100ps
`default_nettype none
module dpc_field_model (
  input  wire logic       i_sys_clk,
  output logic [9:0]      o_field
);
  initial begin
    o_field = 10'h000;
  end

  // square pulses on one channel pin, half period in clock cycles
  task automatic burst(input int ch, input int n, input int half);
    repeat (n) begin
      @(posedge i_sys_clk) o_field[ch] <= 1'b1;
      repeat (half) @(posedge i_sys_clk);
      o_field[ch] <= 1'b0;
      repeat (half) @(posedge i_sys_clk);
    end
  endtask : burst

  // static levels on pins 2..9
  task automatic set_lvl(input logic [7:0] v);
    @(posedge i_sys_clk) o_field[9:2] <= v;
  endtask : set_lvl
endmodule : dpc_field_model
`default_nettype wire

// ===== test/dpc_tb_top.sv
// self-checking bench of the dual pulse counter
`timescale 1ns/100ps
`default_nettype none
module dpc_tb_top;
  import dpc_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_b   = 1'b0;
  logic [9:0]  field;
  logic [7:0]  i_addr    = 8'h00;
  logic [31:0] i_wdata   = 32'h0000_0000;
  logic        i_wr      = 1'b0;
  logic        i_rd      = 1'b0;
  logic [31:0] o_rdata;
  logic        rd_seen   = 1'b0;
  logic [31:0] exp_q[$];
  int          err_count = 0;
  int          comparisons = 0;
  int          n;
  int          c1;
  int          codes[5] = '{2, 4, 8, 16, 40};

  // 40 MHz clock
  always #12.5 i_sys_clk = ~i_sys_clk;

  dpc_field_model u_fld (.i_sys_clk(i_sys_clk), .o_field(field));
  dpc_top #(.DBNC_UNIT_CYC(1)) DUT (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_field_in(field),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_sys_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_sys_clk) i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_sys_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_sys_clk) i_rd <= 1'b0;
  endtask : rd

  task automatic settle();
    repeat (8) @(posedge i_sys_clk);
  endtask : settle

  task automatic tdone(input string s);
    settle();
    $display("test done: %s", s);
  endtask : tdone

  // read data answer one cycle after the strobe, matched to oldest note
  always @(posedge i_sys_clk) begin
    if (rd_seen) begin
      comparisons++;
      if (exp_q.size() == 0 || o_rdata !== exp_q[0]) begin
        err_count++;
        $display("[FAIL] %0t read data %h unexpected", $time, o_rdata);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end else if (i_rst_b && o_rdata !== 32'h0000_0000) begin
      err_count++;
      $display("[FAIL] %0t read data %h outside read slot", $time, o_rdata);
    end
    rd_seen <= i_rd;
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  // watchdog well beyond the expected run length
  initial begin
    #(25 * 60000);
    err_count++;
    report_and_stop();
  end

  initial begin
    void'($urandom(1412));
    repeat (10) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(DPC_OFS_CTRL, 32'h0000_0000);
    rd(DPC_OFS_DBNC1, 32'(DPC_DBNC_RST));
    rd(DPC_OFS_DBNC2, 32'(DPC_DBNC_RST));
    rd(DPC_OFS_COUNT1, 32'h0000_0000);
    rd(DPC_OFS_COUNT2, 32'h0000_0000);
    rd(8'h1c, 32'h0000_0000);
    tdone("reset values");
    // pulses while disabled, write to count ignored
    u_fld.burst(0, 3, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'h0000_0000);
    wr(DPC_OFS_COUNT1, 32'h0000_ffff);
    rd(DPC_OFS_COUNT1, 32'h0000_0000);
    tdone("disabled and read-only");
    // channel 1 enabled by software, channel 2 left off
    wr(DPC_OFS_CTRL, 32'h0000_0001);
    n = 1 + ($urandom % 6);
    fork
      u_fld.burst(0, n, 4);
      u_fld.burst(1, 4, 5);
    join
    settle();
    c1 = n;
    rd(DPC_OFS_COUNT1, 32'(c1));
    rd(DPC_OFS_COUNT2, 32'h0000_0000);
    rd(DPC_OFS_STATUS, 32'h0000_0001);
    tdone("software enable");
    // hardware enable forbidden, then permitted
    wr(DPC_OFS_CTRL, 32'h0000_0000);
    u_fld.set_lvl(8'h01);
    u_fld.burst(0, 2, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'(c1));
    wr(DPC_OFS_CTRL, 32'h0000_0100);
    u_fld.burst(0, 3, 4);
    settle();
    c1 += 3;
    rd(DPC_OFS_COUNT1, 32'(c1));
    rd(DPC_OFS_STATUS, 32'h0000_0001);
    u_fld.set_lvl(8'h00);
    u_fld.burst(0, 2, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'(c1));
    tdone("hardware enable");
    // software clear holds zero, hardware clear only when permitted
    wr(DPC_OFS_CTRL, 32'h0000_0011);
    u_fld.burst(0, 2, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'h0000_0000);
    rd(DPC_OFS_STATUS, 32'h0000_0011);
    wr(DPC_OFS_CTRL, 32'h0000_0001);
    u_fld.set_lvl(8'h04);
    u_fld.burst(0, 2, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'h0000_0002);
    wr(DPC_OFS_CTRL, 32'h0000_1001);
    settle();
    rd(DPC_OFS_COUNT1, 32'h0000_0000);
    u_fld.set_lvl(8'h00);
    u_fld.burst(0, 1, 4);
    settle();
    rd(DPC_OFS_COUNT1, 32'h0000_0001);
    tdone("clears");
    // each debounce code: short glitches dropped, longer pulses counted
    foreach (codes[i]) begin
      wr(DPC_OFS_DBNC2, 32'(codes[i]));
      wr(DPC_OFS_CTRL, 32'h0000_0022);
      wr(DPC_OFS_CTRL, 32'h0000_0002);
      u_fld.burst(1, 2, codes[i] - 1);
      u_fld.burst(1, 3, codes[i] + 3);
      repeat (codes[i]) @(posedge i_sys_clk);
      settle();
      rd(DPC_OFS_DBNC2, 32'(codes[i]));
      rd(DPC_OFS_COUNT2, 32'h0000_0003);
      rd(DPC_OFS_COUNT1, 32'h0000_0001);
    end
    tdone("debounce codes");
    // channel 2 run only by its permitted hardware enable and clear
    wr(DPC_OFS_DBNC1, 32'(DPC_DBNC_1K));
    rd(DPC_OFS_DBNC1, 32'(DPC_DBNC_1K));
    wr(DPC_OFS_CTRL, 32'h0000_2200);
    u_fld.set_lvl(8'h02);
    u_fld.burst(1, 2, 43);
    settle();
    rd(DPC_OFS_COUNT2, 32'h0000_0005);
    u_fld.set_lvl(8'h0a);
    settle();
    rd(DPC_OFS_COUNT2, 32'h0000_0000);
    rd(DPC_OFS_STATUS, 32'h0000_0022);
    tdone("channel 2 hardware");
    // general inputs on pins 4..9, top points read zero
    wr(DPC_OFS_CTRL, 32'h0000_0000);
    n = $urandom % 64;
    u_fld.set_lvl({n[5:0], 2'b00});
    settle();
    rd(DPC_OFS_GPI, 32'(n[5:0]));
    wr(DPC_OFS_GPI, 32'h0000_00ff);
    rd(DPC_OFS_GPI, 32'(n[5:0]));
    tdone("general inputs");
    report_and_stop();
  end
endmodule : dpc_tb_top
`default_nettype wire
